// ==== rtl/tat_pkg.sv ====
// Functional notes
// - Status bits 7:1 read zero until the alarm has lasted over 45.52 ms.
// - Status bit 0 sets when the alarm asserts; a status read clears it.
// - Past 45.52 ms, bit 0 stays part of the 8-bit duration count.
// - Duration count steps by 22.76 ms, reporting 45.52 ms to 5.80 s.
// - Read/write 8-bit limit register holds the longest allowed alarm duration.
// - Duration beyond a limit other than all ones raises the fourth-fan-or-timer fault event.
// - A limit of zero raises the fault at once when the alarm asserts.
// - Pulse-count register holds a 2-bit setting per fan, fan 1 lowest.
// - Setting codes 00, 01, 10, 11 select one, two, three, four pulses.
// - Pulse-count register resets to 0x55, two pulses for every fan.
// - The fourth-fan mask bit suppresses the alert for the timer event.
// - Timing runs only with timer enable set and shared pin routed to alarm.
package tat_pkg;

   // Register offsets
   localparam logic [7:0] TAT_ADDR_STATUS = 8'h79;
   localparam logic [7:0] TAT_ADDR_LIMIT  = 8'h7a;
   localparam logic [7:0] TAT_ADDR_PPR    = 8'h7b;

   // Reset values
   localparam logic [7:0] TAT_RESET_STATUS = 8'h00;
   localparam logic [7:0] TAT_RESET_LIMIT  = 8'h00;
   localparam logic [7:0] TAT_RESET_PPR    = 8'h55;

   // Pulse-count field layout: fan n at bits 2n+1:2n
   localparam int         TAT_FAN_COUNT    = 4;
   localparam int         TAT_FAN_FIELD_W  = 2;

   // Shared pin function code that routes the pin to the thermal alarm
   localparam logic [1:0] TAT_PIN_FUNC_ALARM = 2'h1;

   // Duration count: steps needed before the upper bits show
   localparam logic [7:0] TAT_DUR_VISIBLE  = 8'h02;
   localparam logic [7:0] TAT_DUR_MAX      = 8'hff;

   // Timing: one step is 22.76 ms at 125 MHz
   localparam int         TAT_STEP_TIME_US = 22760;
   localparam int         TAT_CLK_MHZ      = 125;
   localparam int         TAT_STEP_CYCLES  = TAT_STEP_TIME_US * TAT_CLK_MHZ;
   localparam int         TAT_TICK_W       = 22;

   // Register access request from the serial-bus engine
   typedef struct packed {
      logic       read;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tat_reg_req_t;

   // Decoded pulses counted per measurement, one entry per fan
   typedef logic [TAT_FAN_COUNT-1:0][2:0] tat_fan_counts_t;

   // Status register view of the flag and the duration count
   function automatic logic [7:0] tat_status_view(input logic       flag,
                                                  input logic [7:0] dur);
      if (dur >= TAT_DUR_VISIBLE)
         tat_status_view = dur;
      else
         tat_status_view = {7'h00, flag};
   endfunction : tat_status_view

   // Pulse-count code to number of pulses: 00 gives 1 up to 11 gives 4
   function automatic logic [2:0] tat_pulses(input logic [1:0] code);
      tat_pulses = {1'b0, code} + 3'h1;
   endfunction : tat_pulses

endpackage : tat_pkg

// ==== rtl/tat_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module tat_sync
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic d,
   output var  logic q
);

   typedef struct packed {
      logic meta;
      logic stable;
   } tat_sync_state_t;

   tat_sync_state_t st;
   tat_sync_state_t next_st;

   // Only the second stage is visible; idle level of the pin is high
   always_comb
   begin
      next_st.meta   = d;
      next_st.stable = st.meta;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         st <= '{meta: 1'b1, stable: 1'b1};
      else
         st <= next_st;
   end

   assign q = st.stable;

endmodule : tat_sync
`default_nettype wire

// ==== rtl/tat_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tat_timer
   import tat_pkg::*;
#(
   parameter int STEP_CYCLES = TAT_STEP_CYCLES
)
(
   input  wire logic            clk,
   input  wire logic            reset,
   input  wire logic            thermal_alarm_n,
   input  wire logic            timer_enable,
   input  wire logic [1:0]      shared_pin_function,
   input  wire logic            fourth_fan_mask,
   input  wire tat_reg_req_t    reg_req,
   output var  logic [7:0]      reg_rdata,
   output var  logic            fourth_fan_or_timer_fault,
   output var  logic            alert_request,
   output var  tat_fan_counts_t fan_pulses
);

   typedef struct packed {
      logic                  alarm_prev;
      logic                  assertion_flag_lsb;
      logic [7:0]            assertion_time_count;
      logic [TAT_TICK_W-1:0] tick;
      logic                  fault_done;
      logic [7:0]            assertion_time_limit;
      logic [7:0]            pulses_per_revolution;
      logic [7:0]            rdata;
      logic                  fault;
      logic                  alert;
      tat_fan_counts_t       fan_pulses;
   } tat_state_t;

   localparam logic [TAT_TICK_W-1:0] TICK_LAST = TAT_TICK_W'(STEP_CYCLES - 1);

   tat_state_t st;
   tat_state_t next_st;
   logic       alarm_sync_n;
   logic       monitor_on;
   logic       alarm_on;
   logic       alarm_edge;
   logic       step_done;
   logic       read_status;

   // Pin is asynchronous to the time base, so it is resynchronised first
   tat_sync u_alarm_sync
   (
      .clk   (clk),
      .reset (reset),
      .d     (thermal_alarm_n),
      .q     (alarm_sync_n)
   );

   // Monitoring is gated by the enable bit and the pin routing
   assign monitor_on  = timer_enable && (shared_pin_function == TAT_PIN_FUNC_ALARM);
   assign alarm_on    = monitor_on && !alarm_sync_n;
   assign alarm_edge  = alarm_on && !st.alarm_prev;
   assign step_done   = alarm_on && !alarm_edge && (st.tick == TICK_LAST);
   assign read_status = reg_req.read && (reg_req.addr == TAT_ADDR_STATUS);

   // Next-state logic for the whole block
   always_comb
   begin
      next_st            = st;
      next_st.alarm_prev = alarm_on;
      next_st.fault      = 1'b0;

      // Register reads answer one cycle later; unmapped offsets read zero
      if (reg_req.read && reg_req.addr == TAT_ADDR_STATUS)
         next_st.rdata = tat_status_view(st.assertion_flag_lsb,
                                         st.assertion_time_count);
      else if (reg_req.read && reg_req.addr == TAT_ADDR_LIMIT)
         next_st.rdata = st.assertion_time_limit;
      else if (reg_req.read && reg_req.addr == TAT_ADDR_PPR)
         next_st.rdata = st.pulses_per_revolution;
      else if (reg_req.read)
         next_st.rdata = 8'h00;

      // Register writes; the status register ignores writes
      if (reg_req.write && reg_req.addr == TAT_ADDR_LIMIT)
         next_st.assertion_time_limit = reg_req.wdata;
      else if (reg_req.write && reg_req.addr == TAT_ADDR_PPR)
         next_st.pulses_per_revolution = reg_req.wdata;

      // Read clears the flag; a held count survives until the alarm ends
      if (read_status)
      begin
         next_st.assertion_flag_lsb = 1'b0;
         if (!alarm_on)
            next_st.assertion_time_count = 8'h00;
      end

      // A new assertion is processed after the clear so the set wins
      if (alarm_edge)
      begin
         next_st.assertion_flag_lsb   = 1'b1;
         next_st.assertion_time_count = 8'h00;
         next_st.tick                 = '0;
         next_st.fault_done           = 1'b0;
         if (st.assertion_time_limit == 8'h00)
         begin
            next_st.fault      = 1'b1;
            next_st.fault_done = 1'b1;
         end
      end
      else if (alarm_on)
      begin
         // One step per full tick period of continuous assertion
         if (step_done)
         begin
            next_st.tick = '0;
            if (st.assertion_time_count != TAT_DUR_MAX)
               next_st.assertion_time_count = st.assertion_time_count + 8'h01;
         end
         else
            next_st.tick = st.tick + 1'b1;

         // Fault fires once per assertion, the first time the limit is passed
         if (!st.fault_done && st.assertion_time_limit != 8'h00
             && next_st.assertion_time_count > st.assertion_time_limit)
         begin
            next_st.fault      = 1'b1;
            next_st.fault_done = 1'b1;
         end
      end
      else
         next_st.tick = '0;

      // Alert follows the fault unless the fourth-fan mask is set
      next_st.alert = next_st.fault && !fourth_fan_mask;

      // Decoded pulse counts follow the register with no extra delay
      for (int i = 0; i < TAT_FAN_COUNT; i++)
         next_st.fan_pulses[i] = tat_pulses(
            next_st.pulses_per_revolution[i*TAT_FAN_FIELD_W +: TAT_FAN_FIELD_W]);
   end

   // Single state register; reset forces documented power-on values
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st                       <= '0;
         st.assertion_time_count  <= TAT_RESET_STATUS;
         st.assertion_time_limit  <= TAT_RESET_LIMIT;
         st.pulses_per_revolution <= TAT_RESET_PPR;
         st.fan_pulses            <= {3'h2, 3'h2, 3'h2, 3'h2};
      end
      else
         st <= next_st;
   end

   // Outputs come straight from the state register
   assign reg_rdata                 = st.rdata;
   assign fourth_fan_or_timer_fault = st.fault;
   assign alert_request             = st.alert;
   assign fan_pulses                = st.fan_pulses;

   // Checks on the block's own behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_status_read;
      reg_req.read && reg_req.addr == TAT_ADDR_STATUS;
   endsequence

   sequence s_short_count;
      st.assertion_time_count < TAT_DUR_VISIBLE;
   endsequence

   sequence s_long_count;
      st.assertion_time_count >= TAT_DUR_VISIBLE;
   endsequence

   property p_upper_zero;
      (s_short_count and s_status_read) |=> reg_rdata[7:1] == 7'h00;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

   property p_flag_set;
      alarm_edge |=> st.assertion_flag_lsb && st.assertion_time_count == 8'h00;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set on assertion");

   property p_flag_clear;
      (s_status_read and !alarm_edge) |=> !st.assertion_flag_lsb;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by read");

   property p_long_count;
      (s_long_count and s_status_read) |=> reg_rdata == $past(st.assertion_time_count);
   endproperty
   a_long_count: assert property (p_long_count) else $error("count not reported");

   property p_step;
      (step_done && st.assertion_time_count != TAT_DUR_MAX)
         |=> st.assertion_time_count == $past(st.assertion_time_count) + 8'h01;
   endproperty
   a_step: assert property (p_step) else $error("count did not step");

   property p_no_step;
      (alarm_on && !step_done && !alarm_edge && !read_status)
         |=> st.assertion_time_count == $past(st.assertion_time_count);
   endproperty
   a_no_step: assert property (p_no_step) else $error("count moved between steps");

   property p_saturate;
      (alarm_on && !alarm_edge && st.assertion_time_count == TAT_DUR_MAX)
         |=> st.assertion_time_count == TAT_DUR_MAX;
   endproperty
   a_saturate: assert property (p_saturate) else $error("count wrapped");

   property p_limit_write;
      (reg_req.write && reg_req.addr == TAT_ADDR_LIMIT)
         |=> st.assertion_time_limit == $past(reg_req.wdata);
   endproperty
   a_limit_write: assert property (p_limit_write) else $error("limit not written");

   property p_fault_cause;
      fourth_fan_or_timer_fault
         |-> st.assertion_time_limit == 8'h00
             || st.assertion_time_count > st.assertion_time_limit;
   endproperty
   a_fault_cause: assert property (p_fault_cause) else $error("fault without cause");

   property p_zero_limit;
      (alarm_edge && st.assertion_time_limit == 8'h00) |=> fourth_fan_or_timer_fault;
   endproperty
   a_zero_limit: assert property (p_zero_limit) else $error("zero limit fault missing");

   property p_ppr_decode;
      (reg_req.write && reg_req.addr == TAT_ADDR_PPR)
         |=> fan_pulses[3] == {1'b0, $past(reg_req.wdata[7:6])} + 3'h1
             && fan_pulses[0] == {1'b0, $past(reg_req.wdata[1:0])} + 3'h1;
   endproperty
   a_ppr_decode: assert property (p_ppr_decode) else $error("pulse decode wrong");

   property p_ppr_reset;
      $fell(reset) |-> st.pulses_per_revolution == TAT_RESET_PPR
                       && fan_pulses[2] == 3'h2;
   endproperty
   a_ppr_reset: assert property (p_ppr_reset) else $error("pulse reset value wrong");

   property p_mask;
      alert_request |-> fourth_fan_or_timer_fault && !$past(fourth_fan_mask);
   endproperty
   a_mask: assert property (p_mask) else $error("alert not masked");

   // Tick must rest while disabled; an edge right after re-enable is legal
   property p_gate;
      !monitor_on |=> !fourth_fan_or_timer_fault && st.tick == '0;
   endproperty
   a_gate: assert property (p_gate) else $error("timing while disabled");

   // Two faults need a new edge, which takes at least two cycles
   property p_fault_once;
      fourth_fan_or_timer_fault |=> !fourth_fan_or_timer_fault;
   endproperty
   a_fault_once: assert property (p_fault_once) else $error("fault repeated");

   property p_limit_read;
      (reg_req.read && reg_req.addr == TAT_ADDR_LIMIT)
         |=> reg_rdata == $past(st.assertion_time_limit);
   endproperty
   a_limit_read: assert property (p_limit_read) else $error("limit read wrong");

   property p_ppr_read;
      (reg_req.read && reg_req.addr == TAT_ADDR_PPR)
         |=> reg_rdata == $past(st.pulses_per_revolution);
   endproperty
   a_ppr_read: assert property (p_ppr_read) else $error("pulse register read wrong");

   property p_ppr_write;
      (reg_req.write && reg_req.addr == TAT_ADDR_PPR)
         |=> st.pulses_per_revolution == $past(reg_req.wdata);
   endproperty
   a_ppr_write: assert property (p_ppr_write) else $error("pulse register not written");

   // The step that carries the count past the limit; a limit of all ones never trips
   sequence s_step_to_limit;
      step_done && !st.fault_done && st.assertion_time_limit != 8'h00
         && st.assertion_time_limit != TAT_DUR_MAX
         && st.assertion_time_count == st.assertion_time_limit;
   endsequence

   property p_fault_limit;
      s_step_to_limit |=> fourth_fan_or_timer_fault;
   endproperty
   a_fault_limit: assert property (p_fault_limit) else $error("limit fault missing");

   property p_alert_unmasked;
      (fourth_fan_or_timer_fault && !$past(fourth_fan_mask)) |-> alert_request;
   endproperty
   a_alert_unmasked: assert property (p_alert_unmasked) else $error("alert missing");

   property p_status_ro;
      (reg_req.write && reg_req.addr == TAT_ADDR_STATUS && !alarm_edge && !read_status)
         |=> st.assertion_flag_lsb == $past(st.assertion_flag_lsb);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status took a write");

   // Once the alarm ends the count must hold for software to read it
   property p_hold_after;
      (!alarm_on && !read_status)
         |=> st.assertion_time_count == $past(st.assertion_time_count);
   endproperty
   a_hold_after: assert property (p_hold_after) else $error("count moved while idle");

endmodule : tat_timer
`default_nettype wire

// ==== tb/tat_alarm_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far-side driver of the active-low alarm pin; released pin rests high (pull-up)
module tat_alarm_src
(
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [15:0] len,
   output var  logic        thermal_alarm_n
);
   logic [15:0] left = 16'h0000;

   // Hold the alarm low for len cycles after a go pulse
   always_ff @(posedge clk)
   begin
      if (go)
         left <= len;
      else if (left != 16'h0000)
         left <= left - 16'h0001;
   end

   assign thermal_alarm_n = (left == 16'h0000);
endmodule : tat_alarm_src
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
   import tat_pkg::*;
;
   localparam int   STEP = 8;
   logic            clk, reset, timer_enable, fourth_fan_mask, go, alarm_n, fault, alert;
   logic [1:0]      shared_pin_function;
   logic [15:0]     len;
   logic [7:0]      reg_rdata;
   tat_reg_req_t    reg_req;
   tat_fan_counts_t fan_pulses;
   int              error_cnt = 0, samples_checked = 0, n_fault = 0, n_alert = 0;
   int              cyc = 0, fault_cyc = 0, t0 = 0, f0, a0;

   // Short step keeps the long counts inside a brief run
   tat_timer #(.STEP_CYCLES(STEP)) uut (.clk(clk), .reset(reset),
      .thermal_alarm_n(alarm_n), .timer_enable(timer_enable),
      .shared_pin_function(shared_pin_function), .fourth_fan_mask(fourth_fan_mask),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .fourth_fan_or_timer_fault(fault),
      .alert_request(alert), .fan_pulses(fan_pulses));
   tat_alarm_src src (.clk(clk), .go(go), .len(len), .thermal_alarm_n(alarm_n));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Event pulses are counted, since each stands for one cycle only
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (fault === 1'b1)
      begin
         n_fault   <= n_fault + 1;
         fault_cyc <= cyc;
      end
      if (alert === 1'b1)
         n_alert <= n_alert + 1;
   end

   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask : check8

   task automatic final_report();
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_req <= '{read: 1'b0, write: 1'b1, addr: a, wdata: d};
      @(posedge clk);
      reg_req <= '0;
   endtask : wr

   // Read data stands from the cycle after the read edge until the next read
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      reg_req <= '{read: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk);
      reg_req <= '0;
      @(negedge clk);
      check8(what, exp, reg_rdata);
   endtask : rd

   // Assert the alarm for n cycles, then allow the synchroniser to settle
   task automatic pulse_alarm(input int n);
      f0 = n_fault;
      a0 = n_alert;
      @(posedge clk);
      t0 = cyc;
      go  <= 1'b1;
      len <= n[15:0];
      @(posedge clk);
      go <= 1'b0;
      repeat (n + 8) @(posedge clk);
   endtask : pulse_alarm

   task automatic t_reset();
      rd(TAT_ADDR_STATUS, 8'h00, "status");
      rd(TAT_ADDR_LIMIT, 8'h00, "limit");
      rd(TAT_ADDR_PPR, 8'h55, "ppr");
      rd(8'h10, 8'h00, "unmapped");
      for (int i = 0; i < 4; i++)
         check8("fan reset", 8'h02, {5'h00, fan_pulses[i]});
   endtask : t_reset

   task automatic t_regs();
      wr(TAT_ADDR_PPR, 8'h1b);
      @(negedge clk);
      for (int i = 0; i < 4; i++)
         check8("fan 1b", 8'(4 - i), {5'h00, fan_pulses[i]});
      rd(TAT_ADDR_PPR, 8'h1b, "ppr 1b");
      wr(TAT_ADDR_PPR, 8'he4);
      @(negedge clk);
      for (int i = 0; i < 4; i++)
         check8("fan e4", 8'(i + 1), {5'h00, fan_pulses[i]});
      wr(TAT_ADDR_LIMIT, 8'ha5);
      rd(TAT_ADDR_LIMIT, 8'ha5, "limit rw");
      wr(TAT_ADDR_STATUS, 8'hff);
      rd(TAT_ADDR_STATUS, 8'h00, "status ro");
   endtask : t_regs

   // Monitor off by enable and pin routing, then by pin routing alone: nothing timed
   task automatic t_off();
      wr(TAT_ADDR_LIMIT, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         timer_enable        <= (k == 1);
         shared_pin_function <= 2'h0;
         pulse_alarm(20);
         check8("off faults", 8'h00, 8'(n_fault - f0));
         rd(TAT_ADDR_STATUS, 8'h00, "off status");
      end
      shared_pin_function <= TAT_PIN_FUNC_ALARM;
   endtask : t_off

   task automatic t_zero_limit();
      pulse_alarm(5);
      check8("zero faults", 8'h01, 8'(n_fault - f0));
      check8("zero alerts", 8'h01, 8'(n_alert - a0));
      rd(TAT_ADDR_STATUS, 8'h01, "flag set");
      rd(TAT_ADDR_STATUS, 8'h00, "flag clear");
      pulse_alarm(20);
      rd(TAT_ADDR_STATUS, 8'h02, "two steps");
   endtask : t_zero_limit

   task automatic t_limit();
      wr(TAT_ADDR_LIMIT, 8'h03);
      fourth_fan_mask <= 1'b1;
      pulse_alarm(10 * STEP + 4);
      check8("limit faults", 8'h01, 8'(n_fault - f0));
      check8("masked alerts", 8'h00, 8'(n_alert - a0));
      check8("fault late", 8'h01, 8'((fault_cyc - t0) inside {[4 * STEP - 2 : 4 * STEP + 10]}));
      rd(TAT_ADDR_STATUS, 8'h0a, "ten steps");
   endtask : t_limit

   task automatic t_saturate();
      wr(TAT_ADDR_LIMIT, 8'h00);
      fourth_fan_mask <= 1'b0;
      pulse_alarm(262 * STEP);
      check8("one fault", 8'h01, 8'(n_fault - f0));
      rd(TAT_ADDR_STATUS, 8'hff, "saturate");
   endtask : t_saturate

   initial
   begin
      reset               = 1'b1;
      timer_enable        = 1'b1;
      shared_pin_function = TAT_PIN_FUNC_ALARM;
      fourth_fan_mask     = 1'b0;
      go                  = 1'b0;
      len                 = 16'h0000;
      reg_req             = '0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_regs();
      t_off();
      t_zero_limit();
      t_limit();
      t_saturate();
      final_report();
   end

   // Whole sequence needs about 2400 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      final_report();
   end
endmodule : testbench
`default_nettype wire
